// ===== logic/cgcsr_top.sv
// clock generator control, trim and status register block with APB slave
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module cgcsr_top (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 debug_mode,
    input  wire logic                 stop_mode,
    input  wire logic [7:0]           factory_trim,
    input  wire logic                 factory_fine,
    input  wire cgcsr_pkg::cgcsr_stat_t stat_in,
    input  wire logic                 ext_ref_clk,
    output logic                      ext_ref_clock_out,
    output cgcsr_pkg::cgcsr_osc_t     osc_ctrl,
    output logic                      fll_enable,
    output logic [3:0]                bus_clock_divider,
    output logic [1:0]                clock_source_select,
    output logic                      fll_ref_internal_select,
    output logic [1:0]                dco_range_select,
    output logic                      dco_max_32k_option,
    output logic [10:0]               fll_factor,
    output logic [8:0]                irc_period_trim
);

    cgcsr_pkg::cgcsr_state_t s_r;
    cgcsr_pkg::cgcsr_state_t s_nxt;

    logic       wr_en;
    logic       rd_setup;
    logic       mapped;
    logic [1:0] clock_source_select_eff;
    logic       dbg;
    logic       ext_in_use;
    logic       clr_osc;
    logic [7:0] wb;

    // =====================================================================
    // APB decode: zero wait states, read data captured in the setup cycle
    always_comb begin
        mapped = (paddr == cgcsr_pkg::OFS_OSC_DIV) || (paddr == cgcsr_pkg::OFS_TRIM)
              || (paddr == cgcsr_pkg::OFS_STATUS)  || (paddr == cgcsr_pkg::OFS_MODE_SEL);
        wr_en    = psel && penable && pwrite && mapped;
        rd_setup = psel && !penable && !pwrite;
        wb       = pwdata[7:0];
    end

    assign pready  = psel && penable;
    assign pslverr = psel && penable && !mapped;  // unmapped offsets answer with an error

    // =====================================================================
    // derived controls from current state
    always_comb begin
        dbg      = s_r.dbg_s[1];
        clock_source_select_eff = s_r.mode_sel[cgcsr_pkg::SRC_SEL_LSB +: 2];
        if (clock_source_select_eff == 2'h3) begin
            clock_source_select_eff = cgcsr_pkg::SRC_FLL;  // reserved code behaves as FLL output
        end
        // a write taking enable or request from 1 to 0 is the only clearing cause
        clr_osc = wr_en && (paddr == cgcsr_pkg::OFS_OSC_DIV)
               && ((s_r.osc_div[cgcsr_pkg::ERCLK_BIT] && !wb[cgcsr_pkg::ERCLK_BIT])
                || (s_r.osc_div[cgcsr_pkg::OSC_REQ_BIT] && !wb[cgcsr_pkg::OSC_REQ_BIT]));
    end

    // =====================================================================
    // next state
    always_comb begin
        s_nxt = s_r;

        // pins and analog status: two flops before any use
        s_nxt.dbg_s  = {s_r.dbg_s[0], debug_mode};
        s_nxt.stop_s = {s_r.stop_s[0], stop_mode};
        s_nxt.fac_s1 = {factory_trim, factory_fine};
        s_nxt.fac_s2 = s_r.fac_s1;
        s_nxt.st_s1  = stat_in;
        s_nxt.st_s2  = s_r.st_s1;
        s_nxt.stop_q = s_r.stop_s[1];

        // trim reload once the straps are through their synchronisers
        if (s_r.load_cnt != 2'h0) begin
            s_nxt.load_cnt = s_r.load_cnt - 2'h1;
        end
        if (s_r.load_cnt == cgcsr_pkg::LOAD_AT_CNT) begin
            if (dbg) begin
                s_nxt.trim = cgcsr_pkg::RST_TRIM_DBG;
                s_nxt.fine = cgcsr_pkg::RST_FINE_DBG;
            end else begin
                s_nxt.trim = s_r.fac_s2[8:1];
                s_nxt.fine = s_r.fac_s2[0];
            end
        end

        // register writes
        if (wr_en) begin
            unique case (paddr)
                cgcsr_pkg::OFS_OSC_DIV: begin
                    s_nxt.osc_div = wb;
                end
                cgcsr_pkg::OFS_TRIM: begin
                    s_nxt.trim = wb;
                end
                cgcsr_pkg::OFS_STATUS: begin
                    s_nxt.max32 = wb[cgcsr_pkg::MAX32_BIT];
                    s_nxt.fine  = wb[cgcsr_pkg::FINE_BIT];
                    // range writes are dropped in low power and for the reserved code
                    if (!s_r.osc_div[cgcsr_pkg::LOWPWR_BIT]
                        && (wb[cgcsr_pkg::RANGE_SEL_LSB +: 2]
                            != cgcsr_pkg::RANGE_RSVD)) begin
                        s_nxt.range_sel = wb[cgcsr_pkg::RANGE_SEL_LSB +: 2];
                    end
                end
                default: begin
                    s_nxt.mode_sel = wb & 8'hC4;  // only source and reference selects stored
                end
            endcase
        end

        // ready is judged on the bits after this write, so a clearing write is not
        // undone by the stale request or enable; engaged or bypassed external counts
        ext_in_use = s_nxt.osc_div[cgcsr_pkg::ERCLK_BIT]
                  || (s_r.st_s2.clock_mode == cgcsr_pkg::SRC_EXT)
                  || ((s_r.st_s2.clock_mode == cgcsr_pkg::SRC_FLL) && !s_r.st_s2.ref_internal);
        // set wins over a clear in the same cycle
        if (s_r.st_s2.osc_init_done && s_nxt.osc_div[cgcsr_pkg::OSC_REQ_BIT] && ext_in_use) begin
            s_nxt.osc_ready = 1'b1;
        end else if (clr_osc) begin
            s_nxt.osc_ready = 1'b0;
        end

        // capture the enable at stop entry so a late write cannot re-arm it
        if (s_r.stop_s[1] && !s_r.stop_q) begin
            s_nxt.stop_armed = s_r.osc_div[cgcsr_pkg::ERCLK_BIT];
        end
        // the fresh capture is used at the entry edge itself, so no off pulse
        s_nxt.ext_ref_en = s_r.osc_div[cgcsr_pkg::ERCLK_BIT]
            && (!s_r.stop_s[1]
                || (s_r.osc_div[cgcsr_pkg::ESTEN_BIT] && s_nxt.stop_armed));

        // FLL off in bypassed modes only when low power is set and debug is idle
        s_nxt.fll_enable = !(clock_source_select_eff != cgcsr_pkg::SRC_FLL
                             && s_r.osc_div[cgcsr_pkg::LOWPWR_BIT] && !dbg);

        // bus divider factor as a one-hot power of two
        s_nxt.bus_div = 4'h1 << s_r.osc_div[cgcsr_pkg::DIV_CODE_LSB +: 2];

        // multiplication factor from the range actually running
        unique case (s_r.st_s2.dco_range)
            cgcsr_pkg::RANGE_MID: begin
                s_nxt.fll_factor = s_r.max32 ? cgcsr_pkg::FLL_MID_MAX : cgcsr_pkg::FLL_MID;
            end
            cgcsr_pkg::RANGE_HIGH: begin
                s_nxt.fll_factor = s_r.max32 ? cgcsr_pkg::FLL_HIGH_MAX : cgcsr_pkg::FLL_HIGH;
            end
            default: begin
                s_nxt.fll_factor = s_r.max32 ? cgcsr_pkg::FLL_LOW_MAX : cgcsr_pkg::FLL_LOW;
            end
        endcase

        // read data latched in the setup cycle, stable through the access cycle
        if (rd_setup) begin
            s_nxt.prdata = 32'h0000_0000;
            unique case (paddr)
                cgcsr_pkg::OFS_OSC_DIV: begin
                    s_nxt.prdata[7:0] = s_r.osc_div;
                end
                cgcsr_pkg::OFS_TRIM: begin
                    s_nxt.prdata[7:0] = s_r.trim;
                end
                cgcsr_pkg::OFS_STATUS: begin
                    s_nxt.prdata[7:0] = {s_r.st_s2.dco_range,
                                         s_r.max32,
                                         s_r.st_s2.ref_internal,
                                         s_r.st_s2.clock_mode,
                                         s_r.osc_ready,
                                         s_r.fine};
                end
                cgcsr_pkg::OFS_MODE_SEL: begin
                    s_nxt.prdata[7:0] = s_r.mode_sel;
                end
                default: begin
                    s_nxt.prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // =====================================================================
    // state register; trim starts at the debug default until the reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r            <= '0;
            s_r.osc_div    <= cgcsr_pkg::RST_OSC_DIV;
            s_r.trim       <= cgcsr_pkg::RST_TRIM_DBG;
            s_r.fine       <= cgcsr_pkg::RST_FINE_DBG;
            s_r.mode_sel   <= cgcsr_pkg::RST_MODE_SEL;
            s_r.load_cnt   <= cgcsr_pkg::RST_LOAD_CNT;
            s_r.fll_enable <= cgcsr_pkg::RST_FLL_EN;
            s_r.bus_div    <= cgcsr_pkg::RST_BUS_DIV;
            s_r.fll_factor <= cgcsr_pkg::FLL_LOW;
        end else begin
            s_r <= s_nxt;
        end
    end

    // =====================================================================
    // outputs
    assign prdata                  = s_r.prdata;
    assign osc_ctrl.range_high     = s_r.osc_div[cgcsr_pkg::RANGE_BIT];
    assign osc_ctrl.high_gain      = s_r.osc_div[cgcsr_pkg::GAIN_BIT];
    assign osc_ctrl.osc_request    = s_r.osc_div[cgcsr_pkg::OSC_REQ_BIT];
    // gating a clock with a flop is glitch-free only if the enable moves while it is low
    assign ext_ref_clock_out       = ext_ref_clk & s_r.ext_ref_en;
    assign fll_enable              = s_r.fll_enable;
    assign bus_clock_divider       = s_r.bus_div;
    assign clock_source_select     = s_r.mode_sel[cgcsr_pkg::SRC_SEL_LSB +: 2];
    assign fll_ref_internal_select = s_r.mode_sel[cgcsr_pkg::REF_INT_BIT];
    assign dco_range_select        = s_r.range_sel;
    assign dco_max_32k_option      = s_r.max32;
    assign fll_factor              = s_r.fll_factor;
    assign irc_period_trim         = {s_r.trim, s_r.fine};

endmodule

`default_nettype wire

// ===== common/cgcsr_pkg.sv
// constants, field layouts and carrier types of the clock generator control/status registers
package cgcsr_pkg;

    // =====================================================================
    // register byte offsets
    localparam logic [7:0] OFS_OSC_DIV  = 8'h00;
    localparam logic [7:0] OFS_TRIM     = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_MODE_SEL = 8'h0C;

    // =====================================================================
    // reset values
    localparam logic [7:0] RST_OSC_DIV  = 8'h40;
    localparam logic [7:0] RST_MODE_SEL = 8'h04;
    localparam logic [7:0] RST_TRIM_DBG = 8'h80;
    localparam logic       RST_FINE_DBG = 1'b0;
    localparam logic [1:0] RST_LOAD_CNT = 2'h3;
    localparam logic [1:0] LOAD_AT_CNT  = 2'h1;
    localparam logic [3:0] RST_BUS_DIV  = 4'h2;
    localparam logic       RST_FLL_EN   = 1'b1;

    // =====================================================================
    // osc_and_divider_control fields
    localparam int DIV_CODE_LSB  = 6;
    localparam int RANGE_BIT     = 5;
    localparam int GAIN_BIT      = 4;
    localparam int LOWPWR_BIT    = 3;
    localparam int OSC_REQ_BIT   = 2;
    localparam int ERCLK_BIT     = 1;
    localparam int ESTEN_BIT     = 0;

    // clock_status_and_range fields
    localparam int RANGE_SEL_LSB = 6;
    localparam int MAX32_BIT     = 5;
    localparam int IRST_BIT      = 4;
    localparam int MODE_ST_LSB   = 2;
    localparam int OSCI_BIT      = 1;
    localparam int FINE_BIT      = 0;

    // mode select fields
    localparam int SRC_SEL_LSB   = 6;
    localparam int REF_INT_BIT   = 2;

    // =====================================================================
    // codes
    localparam logic [1:0] SRC_FLL    = 2'h0;
    localparam logic [1:0] SRC_INT    = 2'h1;
    localparam logic [1:0] SRC_EXT    = 2'h2;
    localparam logic [1:0] RANGE_RSVD = 2'h3;
    localparam logic [1:0] RANGE_MID  = 2'h1;
    localparam logic [1:0] RANGE_HIGH = 2'h2;

    // FLL multiplication factors
    localparam logic [10:0] FLL_LOW      = 11'h200;
    localparam logic [10:0] FLL_MID      = 11'h400;
    localparam logic [10:0] FLL_HIGH     = 11'h600;
    localparam logic [10:0] FLL_LOW_MAX  = 11'h260;
    localparam logic [10:0] FLL_MID_MAX  = 11'h4C0;
    localparam logic [10:0] FLL_HIGH_MAX = 11'h720;

    // =====================================================================
    // oscillator request group
    typedef struct packed {
        logic range_high;
        logic high_gain;
        logic osc_request;
    } cgcsr_osc_t;

    // status arriving from the analog / FLL side
    typedef struct packed {
        logic [1:0] dco_range;
        logic [1:0] clock_mode;
        logic       ref_internal;
        logic       osc_init_done;
    } cgcsr_stat_t;

    // all state of the block
    typedef struct packed {
        logic [7:0]  osc_div;
        logic [7:0]  trim;
        logic        fine;
        logic [1:0]  range_sel;
        logic        max32;
        logic [7:0]  mode_sel;
        logic [1:0]  load_cnt;
        logic        osc_ready;
        logic        stop_armed;
        logic        stop_q;
        logic [1:0]  dbg_s;
        logic [1:0]  stop_s;
        logic [8:0]  fac_s1;
        logic [8:0]  fac_s2;
        cgcsr_stat_t st_s1;
        cgcsr_stat_t st_s2;
        logic        fll_enable;
        logic        ext_ref_en;
        logic [3:0]  bus_div;
        logic [10:0] fll_factor;
        logic [31:0] prdata;
    } cgcsr_state_t;

endpackage

// ===== sim/cgcsr_assertions.sv
// assertion checker for the clock generator register block, bound to its top
`timescale 1ns/10ps
`default_nettype none
module cgcsr_assertions (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [7:0]             paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   debug_mode,
    input wire cgcsr_pkg::cgcsr_stat_t stat_in,
    input wire logic                   ext_ref_clock_out,
    input wire cgcsr_pkg::cgcsr_osc_t  osc_ctrl,
    input wire logic                   fll_enable,
    input wire logic [3:0]             bus_clock_divider,
    input wire logic [1:0]             clock_source_select,
    input wire logic [1:0]             dco_range_select,
    input wire logic                   dco_max_32k_option,
    input wire logic [10:0]            fll_factor
);
    // ==================================================
    // single domain, so clock and reset are given once
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // completed writes to the control and the status register
    logic wr_ctl;
    logic wr_sts;
    assign wr_ctl = psel && penable && pwrite && paddr == 8'h00;
    assign wr_sts = psel && penable && pwrite && paddr == 8'h08;

    // divider and reference enable are flopped behind the register, so two edges are allowed
    div_follows_a : assert property (
        wr_ctl |-> ##2 bus_clock_divider == (4'h1 << $past(pwdata[7:6], 2)))
        else $error("bus divider does not match written code");
    osc_follows_a : assert property (
        wr_ctl |-> ##2 osc_ctrl == {$past(pwdata[5], 2), $past(pwdata[4], 2), $past(pwdata[2], 2)})
        else $error("oscillator controls do not match written bits");
    ext_off_a : assert property (
        wr_ctl && !pwdata[1] |-> ##2 !ext_ref_clock_out)
        else $error("reference output active while disabled");
    range_rsvd_a : assert property (
        wr_sts && pwdata[7:6] == 2'h3 |-> ##2 dco_range_select == $past(dco_range_select, 2))
        else $error("reserved range code was taken");
    factor_mid_a : assert property (
        (stat_in.dco_range == 2'h1 && !dco_max_32k_option) [*4] |-> fll_factor == 11'h400)
        else $error("mid range factor wrong");
    factor_max_a : assert property (
        (stat_in.dco_range == 2'h2 && dco_max_32k_option) [*4] |-> fll_factor == 11'h720)
        else $error("high range maximum factor wrong");
    // status only trusted once the inputs have settled through the synchroniser
    status_read_a : assert property (
        $stable(stat_in) [*5] ##0 (psel && penable && !pwrite && paddr == 8'h08)
        |-> prdata[7:6] == stat_in.dco_range && prdata[4:2] == {stat_in.ref_internal,
        stat_in.clock_mode})
        else $error("status read does not match settled inputs");
    fll_kept_a : assert property (
        (clock_source_select inside {2'h0, 2'h3} || debug_mode) [*4] |-> fll_enable)
        else $error("loop disabled outside low power bypass");
endmodule

bind cgcsr_top cgcsr_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .debug_mode, .stat_in, .ext_ref_clock_out, .osc_ctrl, .fll_enable,
    .bus_clock_divider, .clock_source_select, .dco_range_select, .dco_max_32k_option,
    .fll_factor);
`default_nettype wire

// ===== sim/test_clock_gen_ctrl_status_regs.sv
// self-checking bench for the clock generator register block
`timescale 1ns/10ps
`default_nettype none
module test_clock_gen_ctrl_status_regs;
    logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic                   debug_mode, stop_mode, factory_fine, ext_ref_clk, ext_ref_clock_out;
    logic                   fll_enable, fll_ref_internal_select, dco_max_32k_option;
    logic [7:0]             paddr, factory_trim, rd;
    logic [31:0]            pwdata, prdata;
    logic [3:0]             bus_clock_divider;
    logic [1:0]             clock_source_select, dco_range_select;
    logic [10:0]            fll_factor;
    logic [8:0]             irc_period_trim;
    cgcsr_pkg::cgcsr_stat_t stat_in;
    cgcsr_pkg::cgcsr_osc_t  osc_ctrl;
    int                     n_fail, total_checks, cycles;

    cgcsr_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .debug_mode, .stop_mode, .factory_trim, .factory_fine, .stat_in,
        .ext_ref_clk, .ext_ref_clock_out, .osc_ctrl, .fll_enable, .bus_clock_divider,
        .clock_source_select, .fll_ref_internal_select, .dco_range_select,
        .dco_max_32k_option, .fll_factor, .irc_period_trim);

    // ==================================================
    // clock and hang guard, the run needs well under a thousand cycles
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            print_verdict();
        end
    end

    // ==================================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // setup then access until pready; an idle edge follows so psel is never set twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // trim reloads on the third edge after release, so wait past it
    task automatic do_reset();
        presetn <= 1'b0;
        tick(4);
        presetn <= 1'b1;
        tick(4);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==================================================
    // scenarios
    task automatic t_div();
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 8'h00, {c[1:0], 6'h34});
            tick(1);
            check(bus_clock_divider, 4'h1 << c);
            check(osc_ctrl, 3'h7);
        end
        apb(1'b1, 8'h00, 8'h40);
        tick(1);
        check(osc_ctrl, 3'h0);
    endtask
    task automatic t_ext();
        apb(1'b1, 8'h00, 8'h43);
        tick(1);
        check(ext_ref_clock_out, 1'b1);
        stop_mode <= 1'b1;
        tick(4);
        check(ext_ref_clock_out, 1'b1);
        stop_mode <= 1'b0;
        apb(1'b1, 8'h00, 8'h42);
        stop_mode <= 1'b1;
        tick(4);
        check(ext_ref_clock_out, 1'b0);
        stop_mode <= 1'b0;
        apb(1'b1, 8'h00, 8'h40);
        tick(3);
        check(ext_ref_clock_out, 1'b0);
        // enable set only after stop entry must not arm the keep
        apb(1'b1, 8'h00, 8'h41);
        stop_mode <= 1'b1;
        tick(4);
        apb(1'b1, 8'h00, 8'h43);
        tick(2);
        check(ext_ref_clock_out, 1'b0);
        stop_mode <= 1'b0;
        tick(4);
        check(ext_ref_clock_out, 1'b1);
    endtask
    // range writes: plain, reserved code, and under the low power bit
    task automatic t_range();
        logic [7:0] ctl[5] = '{8'h40, 8'h40, 8'h48, 8'h40, 8'h40};
        logic [7:0] val[5] = '{8'h80, 8'hC0, 8'h40, 8'h40, 8'h00};
        logic [1:0] exp[5] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h0};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 8'h00, ctl[i]);
            apb(1'b1, 8'h08, val[i]);
            tick(1);
            check(dco_range_select, exp[i]);
        end
        apb(1'b1, 8'h00, 8'h40);
    endtask
    task automatic t_status();
        stat_in <= 6'b10_10_1_0;
        tick(4);
        apb(1'b0, 8'h08, 8'h00);
        check(rd & 8'hDC, 8'h98);
        apb(1'b1, 8'h08, 8'hA0);
        tick(6);
        check(dco_max_32k_option, 1'b1);
        check(fll_factor, 11'h720);
        apb(1'b1, 8'h08, 8'h80);
        stat_in <= 6'b01_01_0_0;
        tick(6);
        check(fll_factor, 11'h400);
        apb(1'b0, 8'h08, 8'h00);
        check(rd & 8'hDC, 8'h44);
    endtask
    // ready flag: set through engaged external mode, kept, then cleared by writes only
    task automatic t_osc();
        logic [5:0] st[6] = '{6'h01, 6'h05, 6'h05, 6'h05, 6'h05, 6'h05};
        logic [7:0] ctl[6] = '{8'h44, 8'h44, 8'h40, 8'h44, 8'h46, 8'h44};
        logic       exp[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 6; i++) begin
            stat_in <= st[i];
            if (i != 1) apb(1'b1, 8'h00, ctl[i]);
            tick(3);
            apb(1'b0, 8'h08, 8'h00);
            check(rd[1], exp[i]);
        end
        apb(1'b1, 8'h00, 8'h40);
    endtask
    task automatic t_fll();
        apb(1'b1, 8'h00, 8'h48);
        apb(1'b1, 8'h0C, 8'h44);
        tick(1);
        check(fll_enable, 1'b0);
        debug_mode <= 1'b1;
        tick(4);
        check(fll_enable, 1'b1);
        debug_mode <= 1'b0;
        apb(1'b1, 8'h0C, 8'hC4);
        tick(1);
        check(fll_enable, 1'b1);
        apb(1'b1, 8'h0C, 8'h80);
        tick(1);
        check(fll_enable, 1'b0);
        check({clock_source_select, fll_ref_internal_select}, 3'h4);
        apb(1'b1, 8'h00, 8'h40);
        tick(1);
        check(fll_enable, 1'b1);
        apb(1'b1, 8'h0C, 8'h04);
    endtask
    // trim, fine bit, an unmapped offset and a debug reset
    task automatic t_trim();
        apb(1'b1, 8'h04, 8'h33);
        apb(1'b1, 8'h08, 8'h01);
        tick(1);
        check(irc_period_trim, 9'h067);
        apb(1'b1, 8'h10, 8'hFF);
        check(err, 1'b1);
        apb(1'b0, 8'h10, 8'h00);
        check({err, rd}, 9'h100);
        debug_mode <= 1'b1;
        do_reset();
        check(irc_period_trim, 9'h100);
        debug_mode <= 1'b0;
    endtask

    // ==================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, debug_mode, stop_mode, stat_in} = '0;
        factory_trim = 8'h5A;
        factory_fine = 1'b1;
        ext_ref_clk = 1'b1;
        do_reset();
        apb(1'b0, 8'h00, 8'h00);
        check(rd, 8'h40);
        check(bus_clock_divider, 4'h2);
        apb(1'b0, 8'h04, 8'h00);
        check(rd, 8'h5A);
        check(irc_period_trim, 9'h0B5);
        t_div();
        t_ext();
        t_range();
        t_status();
        t_osc();
        t_fll();
        t_trim();
        print_verdict();
    end
endmodule
`default_nettype wire
